// ### verilog/madc_pkg.sv
// Purpose: Shared constants and types for the monitor ADC result control block
// Assumes: 40 MHz mclk; register offsets are byte addresses on the register port
// Notes:   Channel enum order follows the single-channel select encoding
package madc_pkg;
   localparam int CLK_NS         = 25;
   localparam int AVG_READS      = 16;
   localparam int VOLT_READ_NS   = 711000;
   localparam int LTEMP_MEAS_NS  = 22760000;
   localparam int RTEMP_MEAS_NS  = 68270000;
   localparam int VOLT_READ_CYC  = VOLT_READ_NS / CLK_NS;
   localparam int LTEMP_READ_CYC = LTEMP_MEAS_NS / (AVG_READS * CLK_NS);
   localparam int RTEMP_READ_CYC = RTEMP_MEAS_NS / (AVG_READS * CLK_NS);
   localparam int TMR_W          = 18;
   localparam int CODE_W         = 10;
   localparam int ACC_W          = 14;

   localparam logic [7:0] ADDR_CFG1   = 8'h40;
   localparam logic [7:0] ADDR_CHSEL  = 8'h55;
   localparam logic [7:0] ADDR_OFS1   = 8'h70;
   localparam logic [7:0] ADDR_OFS2   = 8'h72;
   localparam logic [7:0] ADDR_CFG2   = 8'h73;
   localparam logic [7:0] ADDR_EXTRES = 8'h77;

   localparam int CFG1_START_BIT   = 0;
   localparam int CFG2_AVG_OFF_BIT = 4;
   localparam int CFG2_BYPASS_BIT  = 5;
   localparam int CFG2_SINGLE_BIT  = 6;
   localparam int CHSEL_LSB        = 5;
   localparam int EXT_REM1_LSB     = 0;
   localparam int EXT_LOCAL_LSB    = 2;
   localparam int EXT_REM2_LSB     = 4;

   localparam logic [7:0] RST_CFG1  = 8'h00;
   localparam logic [7:0] RST_CHSEL = 8'h00;
   localparam logic [7:0] RST_OFS   = 8'h00;
   localparam logic [7:0] RST_CFG2  = 8'h00;
   localparam logic [7:0] RST_EXT   = 8'h00;

   localparam logic signed [11:0] TEMP_MAX = 12'h1FF;
   localparam logic signed [11:0] TEMP_MIN = 12'hE00;

   typedef enum logic [2:0] {
      CH_2V5, CH_CORE, CH_SUPPLY, CH_5V, CH_12V, CH_REM1, CH_LOCAL, CH_REM2
   } madc_chan_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } madc_reg_req_s;

   typedef struct packed {
      logic [2:0]        ch;
      logic [CODE_W-1:0] code;
   } madc_result_s;
endpackage

// ### verilog/madc_valmem.sv
// Purpose: Value registers, one word per channel, registered read data
// Assumes: Single writer; one word written per completed measurement
// Notes:   Whole-word write keeps reads free of partial updates
`timescale 1ns/1ps
module madc_valmem #(
   parameter int DW    = 10,
   parameter int DEPTH = 8
) (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [DW-1:0]            wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [DW-1:0]            rd_data_q
);
   logic [DW-1:0] mem_q [DEPTH];

   generate
      if (DW < 1 || DEPTH < 2) begin : g_chk
         $error("madc_valmem: bad DW or DEPTH");
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (wr_en) begin
         mem_q[wr_addr] <= wr_data; // RQ16
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= mem_q[rd_addr];
      end
   end
endmodule

// ### verilog/madc_ctrl.sv
// Purpose: Conversion sequencing, averaging, offset and config registers of the monitor ADC
// Assumes: Register port driven by the serial bus slave on mclk; converter result
//          settles on conv_data before each reading slot ends
// Notes:   Values held as 10-bit codes; temperatures two's complement
//
// Notes on behaviour
// RQ1: Remote temperature results are 10-bit two's complement codes from the converter.
// RQ2: With averaging on, sixteen readings are summed and their average stored.
// RQ3: One averaged remote temperature measurement lasts nominally 68.27 ms.
// RQ4: Two fractional temperature bits, quarter degree each, read at 0x77.
// RQ5: Upper eight code bits are signed whole degrees, low two bits quarters.
// RQ6: Writable offset registers at 0x70 and 0x72 for the two remotes.
// RQ7: Signed 8-bit offset is added to each remote measurement before storing.
// RQ8: Bit 4 of 0x73 stores single unaveraged conversions.
// RQ9: Bit 5 of 0x73 bypasses attenuators on all five voltage inputs.
// RQ10: Bit 6 of 0x73 stops round robin and converts one selected channel.
// RQ11: Host selects channel in bits 7:5 of 0x55, voltages coded 000 to 100.
// RQ12: Select codes 101, 110, 111 choose remote one, local, remote two.
// RQ13: Bit 0 of 0x40 starts monitoring when one, stops when zero.
// RQ14: One voltage reading takes 711 us; sixteen take nominally 11.38 ms.
// RQ15: Single mode repeats the selected channel, updating only its value.
// RQ16: Each result reaches its value register in one single write.
`timescale 1ns/1ps
module madc_ctrl
   import madc_pkg::*;
#(
   parameter int VOLT_CYC  = madc_pkg::VOLT_READ_CYC,
   parameter int LTEMP_CYC = madc_pkg::LTEMP_READ_CYC,
   parameter int RTEMP_CYC = madc_pkg::RTEMP_READ_CYC
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire madc_pkg::madc_reg_req_s    reg_req,
   output logic      [7:0]                 reg_rdata_q,
   output logic                            conv_start_q,
   output madc_pkg::madc_chan_e            conv_chan_q,
   output logic                            atten_bypass_q,
   input  wire logic [madc_pkg::CODE_W-1:0] conv_data,
   input  wire logic [2:0]                 val_raddr,
   output logic      [madc_pkg::CODE_W-1:0] val_rdata_q
);
   import madc_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_CONV, S_STORE} madc_state_e;

   generate
      if (VOLT_CYC < 1 || LTEMP_CYC < 1 || RTEMP_CYC < 1 ||
          VOLT_CYC >= 2**TMR_W || LTEMP_CYC >= 2**TMR_W || RTEMP_CYC >= 2**TMR_W) begin : g_chk
         $error("madc_ctrl: reading slot count out of range");
      end
   endgenerate

   logic [7:0]        cfg1_q, chsel_q, ofs1_q, ofs2_q, cfg2_q, ext_q;
   madc_state_e       state_q;
   madc_chan_e        ch_q;
   logic [3:0]        rd_cnt_q;
   logic [TMR_W-1:0]  tmr_q;
   logic [ACC_W-1:0]  acc_q;
   logic              avg_off_q;
   logic              run;
   logic              single;
   madc_chan_e        first_ch;
   madc_chan_e        next_ch;
   logic              is_temp;
   logic [ACC_W-1:0]  samp;
   logic              last_rd;
   logic [CODE_W-1:0] avg_code;
   logic [7:0]        ofs_sel;
   logic signed [11:0] sum12;
   logic [CODE_W-1:0] store_code;
   madc_result_s      result;

   function automatic logic [TMR_W-1:0] slot_cyc(input madc_chan_e ch);
      logic [TMR_W-1:0] c;
      c = TMR_W'(VOLT_CYC - 1); // RQ14
      if (ch == CH_REM1 || ch == CH_REM2) begin
         c = TMR_W'(RTEMP_CYC - 1); // RQ3
      end else if (ch == CH_LOCAL) begin
         c = TMR_W'(LTEMP_CYC - 1);
      end
      return c;
   endfunction

   assign run      = cfg1_q[CFG1_START_BIT]; // RQ13
   assign single   = cfg2_q[CFG2_SINGLE_BIT]; // RQ10
   assign first_ch = single ? madc_chan_e'(chsel_q[CHSEL_LSB +: 3]) : CH_2V5; // RQ11 RQ12
   assign next_ch  = single ? madc_chan_e'(chsel_q[CHSEL_LSB +: 3])
                            : madc_chan_e'(3'(ch_q + 3'h1)); // RQ15
   assign is_temp  = (ch_q == CH_REM1) || (ch_q == CH_LOCAL) || (ch_q == CH_REM2);
   // Temperatures sign extend, voltages are plain binary
   assign samp     = is_temp ? {{(ACC_W-CODE_W){conv_data[CODE_W-1]}}, conv_data}
                             : {{(ACC_W-CODE_W){1'b0}}, conv_data}; // RQ1
   assign last_rd  = avg_off_q ? 1'b1 : (rd_cnt_q == 4'hF); // RQ2 RQ8
   assign avg_code = avg_off_q ? acc_q[CODE_W-1:0] : acc_q[ACC_W-1:ACC_W-CODE_W]; // RQ2

   always_comb begin
      ofs_sel = 8'h00;
      if (ch_q == CH_REM1) begin
         ofs_sel = ofs1_q;
      end else if (ch_q == CH_REM2) begin
         ofs_sel = ofs2_q;
      end
      // Offset is whole degrees, so it lands above the two quarter bits
      sum12 = $signed({{2{avg_code[CODE_W-1]}}, avg_code})
            + $signed({{2{ofs_sel[7]}}, ofs_sel, 2'b00}); // RQ7 RQ5
      // Saturate rather than wrap so a large offset cannot flip the sign
      if (sum12 > TEMP_MAX) begin
         store_code = TEMP_MAX[CODE_W-1:0];
      end else if (sum12 < TEMP_MIN) begin
         store_code = TEMP_MIN[CODE_W-1:0];
      end else begin
         store_code = sum12[CODE_W-1:0];
      end
      if (!is_temp) begin
         store_code = avg_code;
      end
      result.ch   = ch_q;
      result.code = store_code;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg1_q  <= RST_CFG1;
         chsel_q <= RST_CHSEL;
         ofs1_q  <= RST_OFS;
         ofs2_q  <= RST_OFS;
         cfg2_q  <= RST_CFG2;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            ADDR_CFG1:  cfg1_q  <= reg_req.wdata; // RQ13
            ADDR_CHSEL: chsel_q <= reg_req.wdata; // RQ11
            ADDR_OFS1:  ofs1_q  <= reg_req.wdata; // RQ6
            ADDR_OFS2:  ofs2_q  <= reg_req.wdata; // RQ6
            ADDR_CFG2:  cfg2_q  <= reg_req.wdata; // RQ8 RQ9 RQ10
            default:    ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_CFG1:   reg_rdata_q <= cfg1_q;
            ADDR_CHSEL:  reg_rdata_q <= chsel_q;
            ADDR_OFS1:   reg_rdata_q <= ofs1_q;
            ADDR_OFS2:   reg_rdata_q <= ofs2_q;
            ADDR_CFG2:   reg_rdata_q <= cfg2_q;
            ADDR_EXTRES: reg_rdata_q <= ext_q; // RQ4
            default:     reg_rdata_q <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         atten_bypass_q <= 1'b0;
      end else begin
         atten_bypass_q <= cfg2_q[CFG2_BYPASS_BIT]; // RQ9
      end
   end

   // Mode bits are taken at each measurement start; stopping aborts at once
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q      <= S_IDLE;
         ch_q         <= CH_2V5;
         rd_cnt_q     <= 4'h0;
         tmr_q        <= '0;
         acc_q        <= '0;
         avg_off_q    <= 1'b0;
         conv_start_q <= 1'b0;
         conv_chan_q  <= CH_2V5;
      end else begin
         conv_start_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (run) begin
                  state_q      <= S_CONV;
                  ch_q         <= first_ch;
                  conv_chan_q  <= first_ch;
                  tmr_q        <= slot_cyc(first_ch);
                  rd_cnt_q     <= 4'h0;
                  acc_q        <= '0;
                  avg_off_q    <= cfg2_q[CFG2_AVG_OFF_BIT]; // RQ8
                  conv_start_q <= 1'b1;
               end
            end
            S_CONV: begin
               if (!run) begin
                  state_q <= S_IDLE; // RQ13
               end else if (tmr_q != '0) begin
                  tmr_q <= tmr_q - 1'b1;
               end else begin
                  acc_q    <= ACC_W'(acc_q + samp); // RQ2
                  rd_cnt_q <= rd_cnt_q + 4'h1;
                  if (last_rd) begin
                     state_q <= S_STORE;
                  end else begin
                     tmr_q        <= slot_cyc(ch_q);
                     conv_start_q <= 1'b1;
                  end
               end
            end
            S_STORE: begin
               if (run) begin
                  state_q      <= S_CONV;
                  ch_q         <= next_ch; // RQ10 RQ15
                  conv_chan_q  <= next_ch;
                  tmr_q        <= slot_cyc(next_ch);
                  rd_cnt_q     <= 4'h0;
                  acc_q        <= '0;
                  avg_off_q    <= cfg2_q[CFG2_AVG_OFF_BIT];
                  conv_start_q <= 1'b1;
               end else begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_q <= RST_EXT;
      end else if (state_q == S_STORE) begin
         case (ch_q)
            CH_REM1:  ext_q[EXT_REM1_LSB +: 2]  <= store_code[1:0]; // RQ4
            CH_LOCAL: ext_q[EXT_LOCAL_LSB +: 2] <= store_code[1:0]; // RQ4
            CH_REM2:  ext_q[EXT_REM2_LSB +: 2]  <= store_code[1:0]; // RQ4
            default:  ;
         endcase
      end
   end

   madc_valmem #(
      .DW    (CODE_W),
      .DEPTH (8)
   ) u_valmem (
      .mclk      (mclk),
      .rst       (rst),
      .wr_en     (state_q == S_STORE), // RQ16
      .wr_addr   (result.ch),
      .wr_data   (result.code),
      .rd_addr   (val_raddr),
      .rd_data_q (val_rdata_q)
   );
endmodule

// ### testbench/madc_chk.sv
// Purpose: Port assertions for madc_ctrl
// Assumes: Shadows mirror host writes
// Notes:   Slot gaps allow for handoff and store cycles
`timescale 1ns/1ps
module madc_chk
   import madc_pkg::*;
#(
   parameter int VOLT_CYC  = 4,
   parameter int LTEMP_CYC = 5,
   parameter int RTEMP_CYC = 6
) (
   input wire logic                        mclk,
   input wire logic                        rst,
   input wire madc_pkg::madc_reg_req_s     reg_req,
   input wire logic [7:0]                  reg_rdata_q,
   input wire logic                        conv_start_q,
   input wire madc_pkg::madc_chan_e        conv_chan_q,
   input wire logic                        atten_bypass_q,
   input wire logic [madc_pkg::CODE_W-1:0] conv_data,
   input wire logic [2:0]                  val_raddr,
   input wire logic [madc_pkg::CODE_W-1:0] val_rdata_q
);
   logic [7:0] cfg1_q, chsel_q, ofs1_q, cfg2_q;
   logic [2:0] lc_q;
   logic       gv_q;
   int         age_q, gap_q, sc_q;
   function automatic int slot(logic [2:0] c);
      return (c < 3'd5) ? VOLT_CYC : ((c == 3'd6) ? LTEMP_CYC : RTEMP_CYC);
   endfunction
   always_ff @(posedge mclk) begin
      if (rst) begin
         {cfg1_q, chsel_q, ofs1_q, cfg2_q} <= 32'h00000000;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            ADDR_CFG1:  cfg1_q <= reg_req.wdata;
            ADDR_CHSEL: chsel_q <= reg_req.wdata;
            ADDR_OFS1:  ofs1_q <= reg_req.wdata;
            ADDR_CFG2:  cfg2_q <= reg_req.wdata;
            default:    cfg1_q <= cfg1_q;
         endcase
      end
   end
   // Counters restart whenever monitoring is off, so aborts never skew them
   always_ff @(posedge mclk) begin
      if (rst || !cfg1_q[0]) begin
         age_q <= 0;
         gap_q <= 0;
         gv_q <= 1'b0;
         sc_q <= 0;
         lc_q <= 3'h0;
      end else begin
         age_q <= (age_q == 3) ? 3 : age_q + 1;
         gap_q <= conv_start_q ? 1 : gap_q + 1;
         gv_q <= gv_q | conv_start_q;
         if (conv_start_q) begin
            sc_q <= (3'(conv_chan_q) != lc_q) ? 1 : sc_q + 1;
            lc_q <= 3'(conv_chan_q);
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_bypass;
      reg_req.wr && reg_req.addr == ADDR_CFG2 |-> ##2 atten_bypass_q == $past(reg_req.wdata[5], 2);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass flag wrong");
   property p_ofs_rd;
      reg_req.rd && reg_req.addr == ADDR_OFS1 |=> reg_rdata_q == ofs1_q;
   endproperty
   a_ofs_rd: assert property (p_ofs_rd) else $error("offset readback wrong");
   property p_start;
      $rose(cfg1_q[0]) |=> conv_start_q;
   endproperty
   a_start: assert property (p_start) else $error("no start after run");
   property p_stop;
      !cfg1_q[0] && !$past(cfg1_q[0]) |-> !conv_start_q;
   endproperty
   a_stop: assert property (p_stop) else $error("conversion while stopped");
   property p_hold;
      $changed(conv_chan_q) |-> conv_start_q;
   endproperty
   a_hold: assert property (p_hold) else $error("channel changed mid slot");
   property p_rr;
      $changed(conv_chan_q) && age_q == 3 && !cfg2_q[6]
         |-> 3'(conv_chan_q) == 3'($past(conv_chan_q) + 1);
   endproperty
   a_rr: assert property (p_rr) else $error("round robin order broken");
   property p_single;
      $changed(conv_chan_q) && cfg2_q[6] |-> 3'(conv_chan_q) == chsel_q[7:5];
   endproperty
   a_single: assert property (p_single) else $error("wrong single channel");
   property p_gap;
      conv_start_q && gv_q |-> gap_q >= slot($past(conv_chan_q))
         && gap_q <= slot($past(conv_chan_q)) + 2;
   endproperty
   a_gap: assert property (p_gap) else $error("reading slot length wrong");
   property p_count;
      conv_start_q && 3'(conv_chan_q) != lc_q && age_q == 3 && !cfg2_q[6]
         |-> sc_q == (cfg2_q[4] ? 1 : 16);
   endproperty
   a_count: assert property (p_count) else $error("reading count wrong");
   c_start: cover property ($rose(cfg1_q[0]));
   c_single: cover property ($changed(conv_chan_q) && cfg2_q[6]);
   c_avgoff: cover property (conv_start_q && cfg2_q[4]);
endmodule
bind madc_ctrl madc_chk #(.VOLT_CYC(VOLT_CYC), .LTEMP_CYC(LTEMP_CYC), .RTEMP_CYC(RTEMP_CYC))
   u_madc_chk (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
   .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q), .atten_bypass_q(atten_bypass_q),
   .conv_data(conv_data), .val_raddr(val_raddr), .val_rdata_q(val_rdata_q));

// ### testbench/madc_conv_model.sv
// Purpose: Converter stand-in returning a ramp per channel
// Assumes: One new code per reading slot start
// Notes:   Ramp makes a lost or extra reading visible in the average
`timescale 1ns/1ps
module madc_conv_model
   import madc_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 conv_start_q,
   input  wire madc_pkg::madc_chan_e conv_chan_q,
   input  wire logic [9:0]           base [8],
   input  wire logic [4:0]           n_per,
   output logic      [9:0]           conv_data
);
   logic [4:0] k_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         k_q <= 5'h00;
         conv_data <= 10'h000;
      end else if (conv_start_q) begin
         conv_data <= base[conv_chan_q] + 10'(k_q);
         k_q <= (k_q + 5'h01 == n_per) ? 5'h00 : k_q + 5'h01;
      end
   end
endmodule

// ### testbench/madc_ctrl_tb_top.sv
// Purpose: Self-checking bench for madc_ctrl
// Assumes: Short slot parameters; model ramps codes
// Notes:   Each pass resets, configures, runs and stops
`timescale 1ns/1ps
`define CHK(a, e) begin \
   total_checks++; \
   if ((a) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (e)); \
   end \
end
module madc_ctrl_tb_top;
   import madc_pkg::*;
   localparam logic [7:0] AD [7] = '{8'h40, 8'h55, 8'h70, 8'h72, 8'h73, 8'h77, 8'h41};
   logic          mclk = 1'b0;
   logic          rst = 1'b1;
   madc_reg_req_s req = '0;
   logic [2:0]    vra = 3'h0;
   logic [9:0]    base [8];
   logic [4:0]    n_per = 5'h10;
   logic [7:0]    rdata;
   logic          cst, bypass;
   madc_chan_e    chan;
   logic [9:0]    cdata, vrd;
   logic [31:0]   seed = 32'hE3F61B47;
   int            num_errors = 0;
   int            total_checks = 0;
   always #12.5 mclk = ~mclk;
   madc_ctrl #(.VOLT_CYC(4), .LTEMP_CYC(5), .RTEMP_CYC(6)) u_madc_ctrl (.mclk(mclk), .rst(rst),
      .reg_req(req), .reg_rdata_q(rdata), .conv_start_q(cst), .conv_chan_q(chan),
      .atten_bypass_q(bypass), .conv_data(cdata), .val_raddr(vra), .val_rdata_q(vrd));
   madc_conv_model u_madc_conv_model (.mclk(mclk), .rst(rst), .conv_start_q(cst),
      .conv_chan_q(chan), .base(base), .n_per(n_per), .conv_data(cdata));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] expv(int ch, logic [9:0] b, logic [7:0] o, logic avg);
      int v;
      v = (ch >= 5) ? int'($signed(b)) : int'(b);
      if (avg) v += 7;
      if (ch == 5 || ch == 7) v += 4 * int'($signed(o));
      if (ch == 5 || ch == 7) v = (v > 511) ? 511 : ((v < -512) ? -512 : v);
      return v[9:0];
   endfunction
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 req = '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      #1 req.wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      #1 req.rd = 1'b0;
      `CHK(rdata, e)
   endtask
   task automatic run_pass(input logic [7:0] cfg2, input logic [2:0] sel, input logic [7:0] o1);
      logic [7:0] o2;
      logic [9:0] ev [8];
      int         n;
      int         need;
      o2 = 8'(xs());
      n_per = cfg2[4] ? 5'h01 : 5'h10;
      need = cfg2[6] ? 2 * n_per + 1 : 8 * n_per + 1;
      for (int c = 0; c < 8; c++) base[c] = 10'(xs()) & 10'h3EF;
      // Pushes remote one past the top so the offset must saturate
      if (o1 == 8'h7F) base[5] = 10'h1F0;
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (5) @(posedge mclk);
      #1 rst = 1'b0;
      for (int i = 0; i < 7; i++) rchk(AD[i], 8'h00);
      wreg(ADDR_OFS1, o1);
      wreg(ADDR_OFS2, o2);
      wreg(ADDR_EXTRES, 8'hFF);
      wreg(ADDR_CFG2, cfg2);
      wreg(ADDR_CHSEL, {sel, 5'h00});
      rchk(ADDR_OFS1, o1);
      rchk(ADDR_OFS2, o2);
      rchk(ADDR_CFG2, cfg2);
      rchk(ADDR_CHSEL, {sel, 5'h00});
      rchk(ADDR_EXTRES, 8'h00);
      `CHK(bypass, cfg2[5])
      wreg(ADDR_CFG1, 8'h01);
      n = 0;
      for (int t = 0; t < 5000 && n < need; t++) begin
         @(posedge mclk);
         #1 if (cst === 1'b1) n++;
      end
      `CHK(n, need)
      wreg(ADDR_CFG1, 8'h00);
      for (int c = 0; c < 8; c++) begin
         ev[c] = (cfg2[6] && c != sel) ? 10'h000 : expv(c, base[c], (c == 7) ? o2 : o1, !cfg2[4]);
         @(posedge mclk);
         #1 vra = 3'(c);
         @(posedge mclk);
         #1 `CHK(vrd, ev[c])
      end
      rchk(ADDR_EXTRES, {2'b00, ev[7][1:0], ev[6][1:0], ev[5][1:0]});
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   initial begin
      run_pass(8'h00, 3'h0, 8'h7F);
      run_pass(8'h30, 3'h0, 8'(xs()));
      for (int s = 0; s < 8; s++) begin
         // Odd selects run unaveraged, even ones average sixteen readings
         run_pass((s[0] ? 8'h50 : 8'h40) | 8'(xs() & 32'h20), 3'(s), 8'(xs()));
      end
      results();
   end
endmodule
